/* pkg/ccu_defines.svh */
/*
 * Register offsets, field positions, mode codes and reset values of the capture/compare unit.
 * Assumes it is included by its bare name from any file that needs the constants.
 */
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

// Byte offsets of the word-aligned registers on the APB.
`define CCU_ADDR_VAL_LO   8'h00
`define CCU_ADDR_VAL_HI   8'h04
`define CCU_ADDR_CTRL     8'h08
`define CCU_ADDR_STAT     8'h0C

// Mode field codes.
`define CCU_MODE_OFF      4'h0
`define CCU_MODE_TOGGLE   4'h2
`define CCU_MODE_CAP_FALL 4'h4
`define CCU_MODE_CAP_RISE 4'h5
`define CCU_MODE_CAP_4    4'h6
`define CCU_MODE_CAP_16   4'h7
`define CCU_MODE_CMP_SET  4'h8
`define CCU_MODE_CMP_CLR  4'h9
`define CCU_MODE_CMP_SOFT 4'hA
`define CCU_MODE_CMP_TRIG 4'hB

// Control and status fields.
`define CCU_CTRL_RESET    6'h00
`define CCU_STAT_FLAG     0
`define CCU_STAT_IRQ_EN   1

// Prescaler terminal counts for every 4th and every 16th edge.
`define CCU_PRESC_TC4     4'h3
`define CCU_PRESC_TC16    4'hF

`endif

/* pkg/ccu_pkg.sv */
/*
 * Types shared by the capture/compare unit and its helpers.
 * Assumes ccu_defines.svh is on the include path.
 */
package ccu_pkg;
    `include "ccu_defines.svh"

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic [15:0] first;
        logic [15:0] third;
    } timer_pair_s;

    typedef struct packed {
        logic first;
        logic third;
    } timer_clear_s;

    typedef enum logic [1:0] {PRESC_EACH, PRESC_4, PRESC_16} presc_sel_e;

    // Capture modes occupy codes 0100 to 0111.
    function automatic logic is_capture(input logic [3:0] mode);
        is_capture = (mode[3:2] == 2'h1);
    endfunction

    // Compare modes are the toggle code and codes 1000 to 1011.
    function automatic logic is_compare(input logic [3:0] mode);
        is_compare = (mode == `CCU_MODE_TOGGLE) || (mode[3:2] == 2'h2);
    endfunction
endpackage

/* verilog/ccu_pin_edge.sv */
/*
 * Two-flop synchroniser and edge detector for the unit's pin.
 * Assumes the pin is asynchronous to CLK.
 */
`timescale 1ns/1ns
module ccu_pin_edge (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Raw pin and detected edges.
    input  wire logic pin_in,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } edge_state_s;

    edge_state_s st_r;
    edge_state_s st_nxt;

    // The first stage feeds only the second one.
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Edges are seen only between settled samples.
    assign rise = st_r.s2 & ~st_r.s3;
    assign fall = ~st_r.s2 & st_r.s3;
endmodule // ccu_pin_edge

/* verilog/ccu_prescaler.sv */
/*
 * Capture event prescaler: passes each, every 4th or every 16th edge.
 * Assumes edge pulses are one cycle long and on the same clock.
 */
`timescale 1ns/1ns
`include "ccu_defines.svh"
module ccu_prescaler
    import ccu_pkg::*;
#(
    parameter int CNT_W = 4
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Control.
    input  wire logic       clear,
    input  ccu_pkg::presc_sel_e sel,
    // Events.
    input  wire logic       ev_in,
    output logic            ev_out
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             out;
    } presc_state_s;

    presc_state_s     st_r;
    presc_state_s     st_nxt;
    logic [CNT_W-1:0] tc;

    // Count is cleared outside capture; a mode change between capture settings keeps it.
    always_comb begin
        st_nxt     = st_r;
        st_nxt.out = 1'b0;
        tc         = (sel == PRESC_16) ? `CCU_PRESC_TC16 : `CCU_PRESC_TC4;
        if (clear) begin
            st_nxt.count = '0; // R3
        end else if (ev_in) begin
            if (sel == PRESC_EACH || st_r.count == tc) begin
                st_nxt.count = '0;
                st_nxt.out   = 1'b1;
            end else begin
                st_nxt.count = st_r.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0; // R3
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ev_out = st_r.out;

    chk_presc_clear: assert property (@(posedge clk) disable iff (rst) clear |=> st_r.count == '0) // R3
        else $error("prescaler count not cleared");
endmodule // ccu_prescaler

/* verilog/ccu_top.sv */
/*
 * One capture/compare unit with an APB register slave.
 * Assumes a 20 MHz CLK, timer counts and converter status on CLK, and an asynchronous pin.
 */
// How it works
// R1: Capture selection change may raise flag falsely.
// R2: Software masks and clears flag around changes.
// R3: Prescaler cleared when off, non-capture, reset.
// R4: Capture-to-capture change keeps count, may flag.
// R5: Software disables first, then writes new mode.
// R6: Compare value continuously against selected timer.
// R7: Match drives, clears, toggles or keeps pin; flags.
// R8: Control written zero forces compare latch low.
// R9: Serving timer must run synchronised to clock.
// R10: Software makes the pin an output; the unit raises PIN_OE itself in toggle, set, clear modes.
// R11: Software interrupt mode flags, pin untouched.
// R12: Units 1, 2 trigger clears selected timer.
// R13: Unit 2 trigger starts enabled converter.
// R14: Trigger clear never sets timer flag.
// R15: Identical layouts; value bytes survive resets.
// R16: Mode field codes select unit behaviour.
// R17: Capture copies selected timer and sets flag.
// R18: New capture overwrites; flag held until cleared.
// R19: External timer-select bit picks timer.
// R20: Special trigger is a one-cycle pulse.
// R21: Duty low bits stored, read, otherwise unused.
`timescale 1ns/1ns
`include "ccu_defines.svh"
module ccu_top
    import ccu_pkg::*;
#(
    parameter int UNIT_NUM = 1
) (
    // Clock and reset.
    input  wire logic           CLK,
    input  wire logic           RST,
    // APB slave.
    input  ccu_pkg::apb_req_s     APB_REQ,
    output ccu_pkg::apb_rsp_s     APB_RSP,
    // Timer side.
    input  ccu_pkg::timer_pair_s  TIMER_COUNT,
    input  wire logic           TIMER_SEL,
    output ccu_pkg::timer_clear_s TIMER_CLEAR,
    output logic                TIMER_FLAG_BLOCK,
    // Converter.
    input  wire logic           ADC_ENABLED,
    output logic                ADC_START,
    // Pin.
    input  wire logic           PIN_IN,
    output logic                PIN_OUT,
    output logic                PIN_OE,
    // Interrupt flag and request to the interrupt controller.
    output logic                IRQ_FLAG,
    output logic                IRQ_REQUEST
);
    import ccu_pkg::*;

    typedef struct packed {
        logic [5:0]   ctrl;
        logic [15:0]  value;
        logic         flag;
        logic         irq_en;
        logic         latch;
        logic         oe;
        logic         eq_prev;
        apb_rsp_s     rsp;
        timer_clear_s tclr;
        logic         tblock;
        logic         adc;
        logic         irq;
    } unit_state_s;

    unit_state_s st_r;
    unit_state_s st_nxt;

    logic [3:0]  mode;
    logic [15:0] sel_count;
    logic        eq;
    logic        match_ev;
    logic        cap_ev;
    logic        rise;
    logic        fall;
    logic        presc_ev;
    logic        cap_ev_raw;
    logic        presc_clear;
    presc_sel_e  presc_sel;
    logic        setup;
    logic        access;
    logic        wr;
    logic        wr_ctrl;
    logic        wr_stat;
    logic [3:0]  new_mode;
    logic        trig_unit;

    // Reset value: every field but the value bytes, which survive resets.
    localparam unit_state_s ST_RESET = '{
        ctrl: `CCU_CTRL_RESET, value: 16'h0000, flag: 1'b0, irq_en: 1'b0,
        latch: 1'b0, oe: 1'b0, eq_prev: 1'b0, rsp: '0, tclr: '0,
        tblock: 1'b0, adc: 1'b0, irq: 1'b0};

    // Read data for an offset; unmapped offsets read zero.
    function automatic logic [31:0] read_word(input logic [7:0] a, input unit_state_s s);
        case (a)
            `CCU_ADDR_VAL_LO: read_word = {24'h000000, s.value[7:0]};
            `CCU_ADDR_VAL_HI: read_word = {24'h000000, s.value[15:8]};
            `CCU_ADDR_CTRL:   read_word = {26'h0000000, s.ctrl}; // R21
            `CCU_ADDR_STAT:   read_word = {30'h00000000, s.irq_en, s.flag};
            default:          read_word = 32'h00000000;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `CCU_ADDR_VAL_LO) || (a == `CCU_ADDR_VAL_HI) ||
                 (a == `CCU_ADDR_CTRL) || (a == `CCU_ADDR_STAT);
    endfunction

    // Pin edges, with the synchroniser inside.
    ccu_pin_edge u_edge (
        .clk    (CLK),
        .rst    (RST),
        .pin_in (PIN_IN),
        .rise   (rise),
        .fall   (fall)
    );

    // Prescaler event source and division follow the current mode.
    assign mode        = st_r.ctrl[3:0];
    assign presc_clear = ~is_capture(mode); // R3
    assign presc_ev    = (mode == `CCU_MODE_CAP_FALL) ? fall : rise;
    always_comb begin
        case (mode)
            `CCU_MODE_CAP_4:  presc_sel = PRESC_4;
            `CCU_MODE_CAP_16: presc_sel = PRESC_16;
            default:          presc_sel = PRESC_EACH;
        endcase
    end

    ccu_prescaler #(
        .CNT_W (4)
    ) u_presc (
        .clk    (CLK),
        .rst    (RST),
        .clear  (presc_clear),
        .sel    (presc_sel),
        .ev_in  (presc_ev),
        .ev_out (cap_ev_raw)
    );

    // Compare against the selected timer; an event is the first cycle of equality,
    // so a timer that dwells on one count does not retrigger.
    assign sel_count = TIMER_SEL ? TIMER_COUNT.third : TIMER_COUNT.first; // R19
    assign eq        = (sel_count == st_r.value); // R6
    assign match_ev  = is_compare(mode) & eq & ~st_r.eq_prev; // R6
    assign cap_ev    = cap_ev_raw & is_capture(mode); // R17
    assign trig_unit = (UNIT_NUM == 1) || (UNIT_NUM == 2);

    // APB phases: ready is raised for the access cycle following each setup.
    assign setup    = APB_REQ.psel & ~APB_REQ.penable;
    assign access   = APB_REQ.psel & APB_REQ.penable & st_r.rsp.pready;
    assign wr       = access & APB_REQ.pwrite;
    assign wr_ctrl  = wr & (APB_REQ.paddr == `CCU_ADDR_CTRL);
    assign wr_stat  = wr & (APB_REQ.paddr == `CCU_ADDR_STAT);
    assign new_mode = APB_REQ.pwdata[3:0];

    // Writes go first, hardware events after them so that a set beats a clear; the latch setup of a control write comes last.
    always_comb begin
        st_nxt             = st_r;
        st_nxt.tclr        = '0;
        st_nxt.tblock      = 1'b0;
        st_nxt.adc         = 1'b0;
        st_nxt.eq_prev     = eq;
        st_nxt.rsp.pready  = setup;
        st_nxt.rsp.pslverr = setup & ~mapped(APB_REQ.paddr);
        st_nxt.rsp.prdata  = setup ? read_word(APB_REQ.paddr, st_r) : 32'h00000000;

        if (wr && APB_REQ.paddr == `CCU_ADDR_VAL_LO) begin
            st_nxt.value[7:0] = APB_REQ.pwdata[7:0];
        end
        if (wr && APB_REQ.paddr == `CCU_ADDR_VAL_HI) begin
            st_nxt.value[15:8] = APB_REQ.pwdata[7:0];
        end
        if (wr_stat) begin
            if (APB_REQ.pwdata[`CCU_STAT_FLAG]) begin
                st_nxt.flag = 1'b0;
            end
            st_nxt.irq_en = APB_REQ.pwdata[`CCU_STAT_IRQ_EN];
        end
        if (wr_ctrl) begin
            st_nxt.ctrl = APB_REQ.pwdata[5:0]; // R21
            // A direct hop between capture settings looks like an event.
            if (is_capture(mode) && is_capture(new_mode) && mode != new_mode) begin
                st_nxt.flag = 1'b1; // R1 R4
            end
        end

        // Captured count overwrites any earlier value, and any write this cycle.
        if (cap_ev) begin
            st_nxt.value = sel_count; // R17 R18
            st_nxt.flag  = 1'b1; // R17
        end

        if (match_ev) begin
            st_nxt.flag = 1'b1; // R7
            case (mode) // R16
                `CCU_MODE_TOGGLE:  st_nxt.latch = ~st_r.latch; // R7
                `CCU_MODE_CMP_SET: st_nxt.latch = 1'b1; // R7
                `CCU_MODE_CMP_CLR: st_nxt.latch = 1'b0; // R7
                `CCU_MODE_CMP_TRIG: begin
                    if (trig_unit) begin
                        st_nxt.tclr.first = ~TIMER_SEL; // R12 R20
                        st_nxt.tclr.third = TIMER_SEL; // R12 R20
                        st_nxt.tblock     = 1'b1; // R14
                    end
                    st_nxt.adc = (UNIT_NUM == 2) & ADC_ENABLED; // R13
                end
                default: st_nxt.latch = st_r.latch; // R11
            endcase
        end

        // A control write to off, set or clear mode initialises the latch and outranks a match in the same cycle.
        if (wr_ctrl) begin
            case (new_mode)
                `CCU_MODE_OFF:     st_nxt.latch = 1'b0; // R8
                `CCU_MODE_CMP_SET: st_nxt.latch = 1'b0;
                `CCU_MODE_CMP_CLR: st_nxt.latch = 1'b1;
                default:           st_nxt.latch = st_nxt.latch;
            endcase
        end

        // Only the pin-driving compare modes enable the output.
        st_nxt.oe  = (st_nxt.ctrl[3:0] == `CCU_MODE_TOGGLE) ||
                     (st_nxt.ctrl[3:0] == `CCU_MODE_CMP_SET) ||
                     (st_nxt.ctrl[3:0] == `CCU_MODE_CMP_CLR);
        st_nxt.irq = st_nxt.flag & st_nxt.irq_en;
    end

    // Synchronous reset; value bytes keep their content.
    always_ff @(posedge CLK) begin
        if (RST) begin
            st_r       <= ST_RESET;
            st_r.value <= st_r.value; // R15
        end else begin
            st_r <= st_nxt;
        end
    end

    // Every output is a field of the state register.
    assign APB_RSP          = st_r.rsp;
    assign TIMER_CLEAR      = st_r.tclr;
    assign TIMER_FLAG_BLOCK = st_r.tblock;
    assign ADC_START        = st_r.adc;
    assign PIN_OUT          = st_r.latch;
    assign PIN_OE           = st_r.oe;
    assign IRQ_FLAG         = st_r.flag;
    assign IRQ_REQUEST      = st_r.irq;

    // Checks next to the logic they guard.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_zero_latch: assert property (wr_ctrl && APB_REQ.pwdata[5:0] == 6'h00 |=> !PIN_OUT && !PIN_OE) // R8
        else $error("zero control did not clear latch");
    chk_match_flag: assert property (match_ev |=> IRQ_FLAG) // R7
        else $error("match did not set flag");
    chk_soft_pin: assert property (match_ev && mode == `CCU_MODE_CMP_SOFT && !wr_ctrl |=> $stable(PIN_OUT)) // R11
        else $error("soft compare moved pin");
    chk_set_pin: assert property (match_ev && mode == `CCU_MODE_CMP_SET && !wr_ctrl |=> PIN_OUT) // R7
        else $error("set compare left pin low");
    chk_toggle_pin: assert property (match_ev && mode == `CCU_MODE_TOGGLE && !wr_ctrl |=> PIN_OUT != $past(PIN_OUT)) // R7
        else $error("toggle compare did not toggle");
    chk_trig_clear: assert property (match_ev && mode == `CCU_MODE_CMP_TRIG && trig_unit
                                     |=> (TIMER_CLEAR != '0) && TIMER_FLAG_BLOCK) // R12
        else $error("trigger did not clear timer");
    chk_trig_pulse: assert property (TIMER_CLEAR != '0 |=> TIMER_CLEAR == '0) // R20
        else $error("trigger longer than one cycle");
    chk_block_pair: assert property (TIMER_CLEAR != '0 |-> TIMER_FLAG_BLOCK) // R14
        else $error("clear without flag block");
    chk_adc_start: assert property (ADC_START |-> UNIT_NUM == 2 && $past(ADC_ENABLED)) // R13
        else $error("converter start from wrong unit");
    chk_capture_load: assert property (cap_ev |=> IRQ_FLAG && st_r.value == $past(sel_count)) // R17
        else $error("capture did not load count");
    chk_flag_hold: assert property (IRQ_FLAG && !wr_stat |=> IRQ_FLAG) // R18
        else $error("flag dropped without clear");
    chk_false_flag: assert property (wr_ctrl && is_capture(mode) && is_capture(new_mode)
                                     && mode != new_mode |=> IRQ_FLAG) // R1
        else $error("capture switch did not flag");
endmodule // ccu_top

/* sim/ccu_pin_model.sv */
/*
 * Outside circuit on the unit's pin: a signal source that lets go while the unit drives.
 * Assumes the unit's output enable is high whenever it drives the pin itself.
 */
`timescale 1ns/1ns
module ccu_pin_model (
    // Unit side.
    input  wire logic pin_oe,
    input  wire logic pin_out,
    // Level the bench wants the source to show, and the resulting wire.
    input  wire logic src_level,
    output logic      pin_wire
);
    // The source releases the wire to the unit in the pin-driving compare modes, so both never fight.
    assign pin_wire = pin_oe ? pin_out : src_level;
endmodule // ccu_pin_model

/* sim/tb_timer_capture_compare_unit.sv */
/*
 * Self-checking bench for one capture/compare unit, built as unit two.
 * Assumes the design package, its header and the pin model are compiled first.
 */
`timescale 1ns/1ns
`include "ccu_defines.svh"
module tb_timer_capture_compare_unit;
    import ccu_pkg::*;
    logic         clk      = 1'b0;
    logic         rst      = 1'b1;
    apb_req_s     req      = '0;
    apb_rsp_s     rsp;
    timer_pair_s  cnt      = '0;
    timer_clear_s clr;
    logic         tsel     = 1'b0;
    logic         adc_en   = 1'b0;
    logic         src      = 1'b0;
    logic         ien      = 1'b0;
    logic         adc_go, pin_out, pin_oe, flag, irq, fblk, pin_w, err;
    logic [31:0]  rd;
    int           mismatches = 0;
    int           compares   = 0;

    // Timers and the converter enable come from the bench on CLK, as a synchronised source would.
    ccu_top #(.UNIT_NUM(2)) uut (.CLK(clk), .RST(rst), .APB_REQ(req), .APB_RSP(rsp),
        .TIMER_COUNT(cnt), .TIMER_SEL(tsel), .TIMER_CLEAR(clr), .TIMER_FLAG_BLOCK(fblk),
        .ADC_ENABLED(adc_en), .ADC_START(adc_go), .PIN_IN(pin_w), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .IRQ_FLAG(flag), .IRQ_REQUEST(irq));
    ccu_pin_model pins (.pin_oe(pin_oe), .pin_out(pin_out), .src_level(src), .pin_wire(pin_w));

    // A 50 ns clock.
    always #25 clk = ~clk;

    // Compares one value and counts it.
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Lets n edges pass, then steps past the edge so registered outputs have settled.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One APB transfer; the request holds until pready is seen, read data is taken there.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        bit got = 1'b0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        for (int i = 0; i < 16 && !got; i++) begin
            @(posedge clk);
            if (rsp.pready === 1'b1) begin
                got = 1'b1;
                rd = rsp.prdata;
                err = rsp.pslverr;
            end
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (!got) begin
            mismatches++;
            wrap_up();
        end
    endtask

    // Register write and checked register read.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask

    // Moves the outside source and waits out synchroniser, prescaler and capture latency.
    task automatic pin_to(input logic v);
        @(posedge clk);
        src <= v;
        tick(8);
    endtask

    // Reset values, and the refusal of an unmapped address.
    task automatic t_reset();
        rdc("ctrl", `CCU_ADDR_CTRL, 32'h0);
        rdc("stat", `CCU_ADDR_STAT, 32'h0);
        rdc("hole", 8'h10, 32'h0);
        chk("slverr", err, 1'b1);
        chk("oe", pin_oe, 1'b0);
    endtask

    // Value bytes survive a reset that is not a power-up.
    task automatic t_values();
        wr(`CCU_ADDR_VAL_LO, 32'h5A);
        wr(`CCU_ADDR_VAL_HI, 32'hC3);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc("lo kept", `CCU_ADDR_VAL_LO, 32'h5A);
        rdc("hi kept", `CCU_ADDR_VAL_HI, 32'hC3);
    endtask

    // Rising-edge capture from either timer, overwrite, and a masked request.
    task automatic t_capture();
        @(posedge clk);
        cnt <= '{first: 16'h1234, third: 16'hABCD};
        wr(`CCU_ADDR_CTRL, 32'h35);
        rdc("duty bits", `CCU_ADDR_CTRL, 32'h35);
        wr(`CCU_ADDR_STAT, 32'h1);
        pin_to(1'b1);
        chk("cap flag", flag, 1'b1);
        chk("masked", irq, 1'b0);
        rdc("cap low", `CCU_ADDR_VAL_LO, 32'h34);
        wr(`CCU_ADDR_STAT, 32'h1);
        tsel <= 1'b1;
        pin_to(1'b0);
        chk("no fall cap", flag, 1'b0);
        pin_to(1'b1);
        rdc("recap high", `CCU_ADDR_VAL_HI, 32'hAB);
        rdc("flag held", `CCU_ADDR_STAT, 32'h1);
    endtask

    // Every 4th edge, a direct prescale switch, then falling-edge capture.
    task automatic t_presc();
        wr(`CCU_ADDR_CTRL, 32'h0);
        wr(`CCU_ADDR_CTRL, 32'h6);
        wr(`CCU_ADDR_STAT, 32'h1);
        for (int i = 0; i < 4; i++) begin
            pin_to(1'b0);
            pin_to(1'b1);
            chk("every 4th", flag, i == 3);
        end
        wr(`CCU_ADDR_STAT, 32'h1);
        wr(`CCU_ADDR_CTRL, 32'h7);
        tick(0);
        chk("switch flag", flag, 1'b1);
        wr(`CCU_ADDR_CTRL, 32'h0);
        wr(`CCU_ADDR_CTRL, 32'h4);
        wr(`CCU_ADDR_STAT, 32'h1);
        pin_to(1'b0);
        chk("fall cap", flag, 1'b1);
    endtask

    // One compare match, equality held three cycles, judged on every timer, converter, pin and interrupt output.
    task automatic t_match(input logic [3:0] m, input logic s);
        logic b;
        logic e;
        logic t;
        wr(`CCU_ADDR_CTRL, {28'h0, m});
        wr(`CCU_ADDR_STAT, {30'h0, ien, 1'b1});
        tick(0);
        b = pin_out;
        t = (m == `CCU_MODE_CMP_TRIG);
        e = (m == 4'h8) ? 1'b1 : (m == 4'h9) ? 1'b0 : (m == 4'h2) ? !b : b;
        chk("drive", pin_oe, m == 4'h2 || m == 4'h8 || m == 4'h9);
        if (m[3:1] == 3'h4) chk("init", b, !e);
        @(posedge clk);
        tsel <= s;
        if (s) cnt.third <= 16'h10;
        else cnt.first <= 16'h10;
        tick(1);
        chk("pin", pin_out, e);
        chk("flag", flag, 1'b1);
        chk("req", irq, ien);
        chk("clear", clr, {t & !s, t & s});
        chk("no tflag", fblk, t);
        chk("adc", adc_go, t & adc_en);
        tick(1);
        chk("pulse", {clr, fblk, adc_go}, 4'h0);
        chk("sticky", flag, 1'b1);
        @(posedge clk);
        cnt <= '0;
    endtask

    // Main sequence: reset, registers, capture, then every compare mode.
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_values();
        t_capture();
        t_presc();
        cnt <= '0;
        adc_en <= 1'b1;
        wr(`CCU_ADDR_VAL_LO, 32'h10);
        wr(`CCU_ADDR_VAL_HI, 32'h0);
        ien = 1'b1;
        t_match(`CCU_MODE_CMP_SET, 1'b0);
        t_match(`CCU_MODE_CMP_CLR, 1'b0);
        t_match(`CCU_MODE_TOGGLE, 1'b1);
        t_match(`CCU_MODE_CMP_SOFT, 1'b0);
        t_match(`CCU_MODE_CMP_TRIG, 1'b1);
        ien = 1'b0;
        adc_en <= 1'b0;
        t_match(`CCU_MODE_CMP_TRIG, 1'b0);
        t_match(`CCU_MODE_CMP_SET, 1'b0);
        wr(`CCU_ADDR_CTRL, 32'h0);
        tick(0);
        chk("latch off", pin_out, 1'b0);
        wrap_up();
    end

    // Cuts a hang short.
    initial begin
        #2000000;
        mismatches++;
        wrap_up();
    end
endmodule // tb_timer_capture_compare_unit
